// ### dws_pkg.sv
// Shared constants and command carrier for the dual wiper shift and address block.
package dws_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus addressing.
    localparam logic [4:0] ADDR_PREFIX = 5'h0b;

    ////////////////////////////////////////////////////////////////////////////////
    // Quick-command codes handled here.
    localparam logic [3:0] OP_HALVE_ONE = 4'h3;
    localparam logic [3:0] OP_HALVE_ALL = 4'h4;
    localparam logic [3:0] OP_DOUBLE_ONE = 4'h8;
    localparam logic [3:0] OP_DOUBLE_ALL = 4'h9;

    ////////////////////////////////////////////////////////////////////////////////
    // Channel select codes in the low bits of a command byte.
    localparam logic [2:0] CHAN_FIRST = 3'h1;
    localparam logic [2:0] CHAN_THIRD = 3'h3;

    ////////////////////////////////////////////////////////////////////////////////
    // Default wiper geometry and reset values.
    localparam int WIPER_WIDTH_DEFAULT = 8;
    localparam int NUM_CHANNELS = 2;
    localparam logic RESET_PULSE = 1'b0;
    localparam logic RESET_WRITE_PROTECT = 1'b1;
    localparam logic [1:0] RESET_ADDR_SELECT = 2'h0;

    // One decoded quick command as delivered by the serial front end.
    typedef struct packed {
        logic [6:0] slave_addr;
        logic [3:0] opcode;
        logic [2:0] channel;
    } dws_cmd_type;

endpackage : dws_pkg

// ### dws_tap_decoder.sv
// Registered one-hot tap selector for one wiper channel.
`timescale 1ns/10ps
module dws_tap_decoder #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Wiper setting in
    input wire logic [WIDTH-1:0] setting,
    // One switch per tap, bit 0 is the B-terminal end
    output logic [(2**WIDTH)-1:0] tap_reg
);

    localparam int TAPS = 2**WIDTH;

    logic [TAPS-1:0] tap_next;

    always_comb begin
        tap_next = '0;
        tap_next[setting] = 1'b1;
    end

    // Reset value matches the midscale wiper; after a wiper change the switch follows the setting one edge later.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            tap_reg <= {{(TAPS/2-1){1'b0}}, 1'b1, {(TAPS/2){1'b0}}};
        end else begin
            tap_reg <= tap_next;
        end
    end

endmodule : dws_tap_decoder

// ### dws_wiper_shift.sv
// Dual wiper registers with doubling and halving quick commands, address match and taps.
// How it works
// - Double shifts left, halve shifts right.
// - Shifts happen only through four quick commands.
// - Nine doublings from zero, eight halvings from full.
// - Floating write-protect pin reads low, protection on.
// - Respond only when address equals prefix plus straps.
// - Setting decodes to one of 2**width taps.
// - Setting zero is B end, each step up.
// - Exactly one tap switch closed at all times.
// - Codes 3/4 halve one/all; 8/9 double.
// - Channel codes 001 and 011 only valid; codes 4 and 9 ignore the channel.
`timescale 1ns/10ps
module dws_wiper_shift #(
    parameter int WIDTH = dws_pkg::WIPER_WIDTH_DEFAULT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Address straps and write-protect pin
    input wire logic addr_select_hi,
    input wire logic addr_select_lo,
    input wire logic wp_pin_level,
    input wire logic wp_pin_driven,
    // Command from the serial front end
    input wire logic cmd_valid,
    input wire dws_pkg::dws_cmd_type cmd,
    // Answers
    output logic addr_ack_reg,
    output logic cmd_done_reg,
    output logic cmd_reject_reg,
    output logic write_protect_reg,
    // Wiper state and tap switches
    output logic [WIDTH-1:0] wiper_channel_first,
    output logic [WIDTH-1:0] wiper_channel_third,
    output logic [(2**WIDTH)-1:0] tap_first_reg,
    output logic [(2**WIDTH)-1:0] tap_third_reg
);

    localparam logic [WIDTH-1:0] FULL_SCALE = {WIDTH{1'b1}};
    localparam logic [WIDTH-1:0] ZERO_SCALE = {WIDTH{1'b0}};
    localparam logic [WIDTH-1:0] ONE_STEP = {{(WIDTH-1){1'b0}}, 1'b1};
    localparam logic [WIDTH-1:0] MID_SCALE = {1'b1, {(WIDTH-1){1'b0}}};

    ////////////////////////////////////////////////////////////////////////////////
    // Shift arithmetic.

    // Zero steps to one so a doubling chain can climb out of zero scale; a set top bit
    // clamps to full scale, which is what makes the chain end after WIDTH+1 steps.
    function automatic logic [WIDTH-1:0] double_value(input logic [WIDTH-1:0] v);
        if (v == ZERO_SCALE) begin
            double_value = ONE_STEP;
        end else if (v[WIDTH-1]) begin
            double_value = FULL_SCALE;
        end else begin
            double_value = {v[WIDTH-2:0], 1'b0};
        end
    endfunction : double_value

    function automatic logic [WIDTH-1:0] halve_value(input logic [WIDTH-1:0] v);
        halve_value = {1'b0, v[WIDTH-1:1]};
    endfunction : halve_value

    ////////////////////////////////////////////////////////////////////////////////
    // Straps and write protect.

    logic [1:0] addr_select_reg;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            addr_select_reg <= dws_pkg::RESET_ADDR_SELECT;
        end else begin
            addr_select_reg <= {addr_select_hi, addr_select_lo};
        end
    end

    // An undriven pin is pulled low internally, so protection is the default.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            write_protect_reg <= dws_pkg::RESET_WRITE_PROTECT;
        end else begin
            write_protect_reg <= !(wp_pin_driven && wp_pin_level);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Command decode.

    logic addr_hit;
    logic op_halve;
    logic op_double;
    logic op_all;
    logic op_known;
    logic chan_ok;
    logic accept;
    logic [dws_pkg::NUM_CHANNELS-1:0] chan_hit;

    always_comb begin
        addr_hit = cmd.slave_addr == {dws_pkg::ADDR_PREFIX, addr_select_reg};
        op_halve = (cmd.opcode == dws_pkg::OP_HALVE_ONE) ||
                   (cmd.opcode == dws_pkg::OP_HALVE_ALL);
        op_double = (cmd.opcode == dws_pkg::OP_DOUBLE_ONE) ||
                    (cmd.opcode == dws_pkg::OP_DOUBLE_ALL);
        op_all = (cmd.opcode == dws_pkg::OP_HALVE_ALL) ||
                 (cmd.opcode == dws_pkg::OP_DOUBLE_ALL);
        op_known = op_halve || op_double;
        chan_hit[0] = op_all || (cmd.channel == dws_pkg::CHAN_FIRST);
        chan_hit[1] = op_all || (cmd.channel == dws_pkg::CHAN_THIRD);
        chan_ok = |chan_hit;
        accept = cmd_valid && addr_hit && op_known && chan_ok;
    end

    // Address acknowledge is independent of whether the opcode is one handled here.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            addr_ack_reg <= dws_pkg::RESET_PULSE;
            cmd_done_reg <= dws_pkg::RESET_PULSE;
            cmd_reject_reg <= dws_pkg::RESET_PULSE;
        end else begin
            addr_ack_reg <= cmd_valid && addr_hit;
            cmd_done_reg <= accept;
            cmd_reject_reg <= cmd_valid && addr_hit && !(op_known && chan_ok);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Wiper registers.

    logic [WIDTH-1:0] wiper_setting_register [dws_pkg::NUM_CHANNELS];

    // An all-channel command updates both wipers on the same edge, which is the
    // synchronous update; single-channel commands move one wiper at a time.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            for (int i = 0; i < dws_pkg::NUM_CHANNELS; i++) begin
                wiper_setting_register[i] <= MID_SCALE;
            end
        end else begin
            for (int i = 0; i < dws_pkg::NUM_CHANNELS; i++) begin
                if (accept && chan_hit[i]) begin
                    if (op_double) begin
                        wiper_setting_register[i] <= double_value(wiper_setting_register[i]);
                    end else begin
                        wiper_setting_register[i] <= halve_value(wiper_setting_register[i]);
                    end
                end
            end
        end
    end

    assign wiper_channel_first = wiper_setting_register[0];
    assign wiper_channel_third = wiper_setting_register[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Tap decoders.

    dws_tap_decoder #(
        .WIDTH(WIDTH)
    ) u_tap_first (
        .clk(clk),
        .nrst(nrst),
        .setting(wiper_setting_register[0]),
        .tap_reg(tap_first_reg)
    );

    dws_tap_decoder #(
        .WIDTH(WIDTH)
    ) u_tap_third (
        .clk(clk),
        .nrst(nrst),
        .setting(wiper_setting_register[1]),
        .tap_reg(tap_third_reg)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    logic acc_dbl_first;
    logic acc_hlv_first;

    assign acc_dbl_first = accept && op_double && chan_hit[0];
    assign acc_hlv_first = accept && op_halve && chan_hit[0];

    double_shift_a: assert property (@(posedge clk) disable iff (!nrst)
        acc_dbl_first && (wiper_channel_first != ZERO_SCALE) && !wiper_channel_first[WIDTH-1]
        |=> wiper_channel_first == {$past(wiper_channel_first[WIDTH-2:0]), 1'b0})
        else $error("doubling did not shift the first wiper left");

    halve_shift_a: assert property (@(posedge clk) disable iff (!nrst)
        acc_hlv_first |=> wiper_channel_first == ($past(wiper_channel_first) >> 1))
        else $error("halving did not shift the first wiper right");

    quick_only_a: assert property (@(posedge clk) disable iff (!nrst)
        $past(nrst) && !$past(accept) |-> $stable(wiper_channel_first) &&
        $stable(wiper_channel_third))
        else $error("wiper moved without an accepted quick command");

    zero_climb_a: assert property (@(posedge clk) disable iff (!nrst)
        accept && op_double && chan_hit[1] && (wiper_channel_third == ZERO_SCALE)
        |=> wiper_channel_third == ONE_STEP)
        else $error("doubling from zero did not reach one");

    full_clamp_a: assert property (@(posedge clk) disable iff (!nrst)
        acc_dbl_first && wiper_channel_first[WIDTH-1] |=> wiper_channel_first == FULL_SCALE)
        else $error("doubling past the top did not saturate");

    zero_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        acc_hlv_first && (wiper_channel_first == ZERO_SCALE)
        |=> wiper_channel_first == ZERO_SCALE)
        else $error("halving at zero changed the setting");

    wp_default_a: assert property (@(posedge clk) disable iff (!nrst)
        !wp_pin_driven |=> write_protect_reg)
        else $error("floating write-protect pin did not enable protection");

    addr_match_a: assert property (@(posedge clk) disable iff (!nrst)
        $past(nrst) && $past(nrst, 2) |-> addr_ack_reg == ($past(cmd_valid) &&
        ($past(cmd.slave_addr) == {dws_pkg::ADDR_PREFIX, $past(addr_select_hi, 2),
        $past(addr_select_lo, 2)})))
        else $error("address acknowledge disagrees with strap match");

    tap_onehot_a: assert property (@(posedge clk) disable iff (!nrst)
        $onehot(tap_first_reg) && $onehot(tap_third_reg))
        else $error("tap select is not one-hot");

    tap_position_a: assert property (@(posedge clk) disable iff (!nrst)
        $past(nrst) |-> tap_third_reg[$past(wiper_channel_third)])
        else $error("closed tap does not follow the setting");

    bad_channel_a: assert property (@(posedge clk) disable iff (!nrst)
        cmd_valid && addr_hit && !op_all && (cmd.channel != dws_pkg::CHAN_FIRST) &&
        (cmd.channel != dws_pkg::CHAN_THIRD) |=> cmd_reject_reg && !cmd_done_reg)
        else $error("invalid channel code was not rejected");

    all_halve_a: assert property (@(posedge clk) disable iff (!nrst)
        accept && (cmd.opcode == dws_pkg::OP_HALVE_ALL)
        |=> (wiper_channel_first == ($past(wiper_channel_first) >> 1)) &&
            (wiper_channel_third == ($past(wiper_channel_third) >> 1)))
        else $error("halve-all did not halve both wipers");

endmodule : dws_wiper_shift

// ### dws_host_model.sv
// Host-side model that presents quick commands to the wiper block.
`timescale 1ns/10ps
module dws_host_model (
    // Clock
    clk,
    // Command out
    cmd_valid,
    cmd
);
    input wire logic clk;
    output logic cmd_valid;
    output dws_pkg::dws_cmd_type cmd;

    initial begin
        cmd_valid = 1'b0;
        cmd = '0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // After the pulse the fields go to their inverse, so a stale command never looks fresh.
    task automatic send(input dws_pkg::dws_cmd_type c);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd <= c;
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd <= ~c;
    endtask : send
endmodule : dws_host_model

// ### dws_wiper_shift_tb.sv
// Self-checking bench for the dual wiper shift and address block.
`timescale 1ns/10ps
module dws_wiper_shift_tb;
    localparam int W = 8;
    localparam int FULL = (1 << W) - 1;
    logic clk;
    logic nrst;
    logic addr_select_hi;
    logic addr_select_lo;
    logic wp_pin_level;
    logic wp_pin_driven;
    logic cmd_valid;
    dws_pkg::dws_cmd_type cmd;
    logic addr_ack_reg, cmd_done_reg, cmd_reject_reg, write_protect_reg;
    logic [W-1:0] wiper_channel_first, wiper_channel_third;
    logic [(2**W)-1:0] tap_first_reg, tap_third_reg;
    logic [3:0] ops [4] = '{4'h3, 4'h4, 4'h8, 4'h9};
    int n_fail = 0;
    int checks = 0;
    int w1 = 1 << (W - 1);
    int w3 = 1 << (W - 1);

    dws_wiper_shift #(.WIDTH(W)) dut (.clk(clk), .nrst(nrst),
        .addr_select_hi(addr_select_hi), .addr_select_lo(addr_select_lo),
        .wp_pin_level(wp_pin_level), .wp_pin_driven(wp_pin_driven),
        .cmd_valid(cmd_valid), .cmd(cmd), .addr_ack_reg(addr_ack_reg),
        .cmd_done_reg(cmd_done_reg), .cmd_reject_reg(cmd_reject_reg),
        .write_protect_reg(write_protect_reg), .wiper_channel_first(wiper_channel_first),
        .wiper_channel_third(wiper_channel_third), .tap_first_reg(tap_first_reg),
        .tap_third_reg(tap_third_reg));
    dws_host_model host (.clk(clk), .cmd_valid(cmd_valid), .cmd(cmd));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic conclude();
        if (n_fail == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude

    // Doubling zero gives one, and anything with the top bit set clamps at full scale.
    function automatic int dbl(input int v);
        if (v == 0) return 1;
        if (v >= (1 << (W - 1))) return FULL;
        return v * 2;
    endfunction : dbl

    task automatic do_cmd(input logic [6:0] a, input logic [3:0] op, input logic [2:0] ch);
        dws_pkg::dws_cmd_type c;
        bit hit;
        bit one;
        bit ok;
        c = '{a, op, ch};
        hit = (a == {dws_pkg::ADDR_PREFIX, addr_select_hi, addr_select_lo});
        one = (ch == 3'h1 || ch == 3'h3);
        ok = hit && (((op == 4'h3 || op == 4'h8) && one) || op == 4'h4 || op == 4'h9);
        if (ok && (op == 4'h4 || op == 4'h9 || ch == 3'h1))
            w1 = op[3] ? dbl(w1) : w1 / 2;
        if (ok && (op == 4'h4 || op == 4'h9 || ch == 3'h3))
            w3 = op[3] ? dbl(w3) : w3 / 2;
        host.send(c);
        #1;
        chk(addr_ack_reg, hit);
        chk(cmd_done_reg, ok);
        chk(cmd_reject_reg, hit && !ok);
        chk(wiper_channel_first, w1);
        chk(wiper_channel_third, w3);
        @(posedge clk);
        #1;
        chk(tap_first_reg, 256'h1 << w1);
        chk(tap_third_reg, 256'h1 << w3);
    endtask : do_cmd

    initial begin
        logic [6:0] me;
        nrst = 1'b0;
        addr_select_hi = 1'b0;
        addr_select_lo = 1'b0;
        wp_pin_level = 1'b0;
        wp_pin_driven = 1'b0;
        me = {dws_pkg::ADDR_PREFIX, 2'h0};
        void'($urandom(32'he7aa));
        repeat (7) @(posedge clk);
        #1;
        chk(tap_first_reg, 256'h1 << w1);
        chk(cmd_done_reg, 1'b0);
        @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk(wiper_channel_first, w1);
        chk(tap_third_reg, 256'h1 << w3);
        chk(write_protect_reg, 1'b1);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            {wp_pin_driven, wp_pin_level} <= i[1:0];
            repeat (2) @(posedge clk);
            #1;
            chk(write_protect_reg, i != 3);
        end
        do_cmd(me, 4'h8, 3'h1);
        repeat (9) do_cmd(me, 4'h3, 3'h1);
        repeat (10) do_cmd(me, 4'h8, 3'h1);
        do_cmd(me, 4'h4, 3'h0);
        do_cmd(me, 4'h3, 3'h3);
        do_cmd(me, 4'h9, 3'h7);
        do_cmd(me, 4'h8, 3'h2);
        do_cmd(me, 4'hc, 3'h1);
        // Walk the third wiper down to zero so the climb out of zero scale is exercised.
        repeat (8) do_cmd(me, 4'h3, 3'h3);
        do_cmd(me, 4'h8, 3'h3);
        // Straps are sampled continuously, so give them two edges to settle.
        for (int s = 0; s < 4; s++) begin
            @(posedge clk);
            {addr_select_hi, addr_select_lo} <= s[1:0];
            repeat (2) @(posedge clk);
            for (int o = 0; o < 4; o++)
                do_cmd({dws_pkg::ADDR_PREFIX, o[1:0]}, ops[o], 3'h3);
        end
        for (int k = 0; k < 60; k++) begin
            me = {dws_pkg::ADDR_PREFIX, addr_select_hi, addr_select_lo};
            do_cmd(($urandom_range(3) == 0) ? 7'($urandom) : me,
                (k % 5 == 4) ? 4'($urandom) : ops[$urandom_range(3)],
                3'($urandom_range(3)));
        end
        conclude();
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        conclude();
    end
endmodule : dws_wiper_shift_tb
